// ### rtl/mpsh_defs.svh
// constants for the multi-protocol serial host port
`ifndef MPSH_DEFS_SVH
`define MPSH_DEFS_SVH

`define MPSH_CLK_HZ       125000000
`define MPSH_HZ_PER_MHZ   1000000
`define MPSH_SETTLE_US    20
`define MPSH_INIT_CYC     4'h8
`define MPSH_SYNC_W       6

`define MPSH_DEF_I2C_ADDR 8'h50
`define MPSH_DEF_BAUD     4'h4
`define MPSH_BAUD_MIN     4'h1
`define MPSH_BAUD_MAX     4'h8

`define MPSH_BAUD_1       300
`define MPSH_BAUD_2       1200
`define MPSH_BAUD_3       2400
`define MPSH_BAUD_4       9600
`define MPSH_BAUD_5       14400
`define MPSH_BAUD_6       19200
`define MPSH_BAUD_7       57600
`define MPSH_BAUD_8       115200

`define MPSH_PREFIX       8'hfe
`define MPSH_CMD_BAUD     8'h61
`define MPSH_CMD_ADDR     8'h62
`define MPSH_CMD_CURSOR   8'h45
`define MPSH_CMD_CONTRAST 8'h52
`define MPSH_CMD_BRIGHT   8'h53
`define MPSH_CMD_GLYPH    8'h54
`define MPSH_CMD_RAW      8'hfe
`define MPSH_GLYPH_LEN    4'h9
`define MPSH_ONE_LEN      4'h1

`endif

// ### rtl/mpsh_pkg.sv
// types for the multi-protocol serial host port
package mpsh_pkg;

  typedef enum logic [1:0] {MODE_UART, MODE_SPI, MODE_I2C} mpsh_mode_t;
  typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} mpsh_urx_t;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_DATA, I_DACK
  } mpsh_i2c_t;
  typedef enum logic [1:0] {C_IDLE, C_CODE, C_PARAM, C_SKIP} mpsh_cmd_t;
  typedef enum logic [1:0] {P_NONE, P_ADDR, P_BAUD} mpsh_pend_t;

  typedef struct packed {
    logic       init_done;
    logic [3:0] init;
    mpsh_mode_t mode;
    logic [7:0] i2c_addr;
    logic [3:0] baud;
    logic       nv_wr;
    logic [7:0] out_d;
    logic       out_v;
    logic       spi_prev;
    mpsh_urx_t  urx;
    logic [19:0] ucnt;
    logic [2:0] ubit;
    logic [7:0] ush;
    mpsh_i2c_t  i2c;
    logic [3:0] ibit;
    logic [7:0] ish;
    logic       sda_oe_n;
    logic       sda_o;
    logic       scl_p;
    logic       sda_p;
    mpsh_cmd_t  cmd;
    mpsh_pend_t kind;
    logic [3:0] skip;
    mpsh_pend_t pend;
    logic [7:0] pval;
    logic [15:0] settle;
  } mpsh_top_st_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] byte_q;
    logic       tgl;
  } mpsh_spi_st_t;

endpackage

// ### rtl/mpsh_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module mpsh_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } mpsh_sync_st_t;

  mpsh_sync_st_t s_r;
  mpsh_sync_st_t s_nxt;
  logic [W-1:0]  agree;

  // stage one feeds stage two only
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree[i] = (s_r.s2[i] == s_r.s3[i]) ? s_r.s3[i] : s_r.q[i];
  end

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q  = agree;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

// ### rtl/mpsh_spi_link.sv
// spi target shifter on the serial clock, hands bytes over by toggle
`timescale 1ns/1ps
module mpsh_spi_link
  import mpsh_pkg::*;
(
  input  wire logic       sck,
  input  wire logic       resetn,
  input  wire logic       serial_target_select_in_n,
  input  wire logic       sdi,
  output logic      [7:0] byte_q,
  output logic            byte_tgl
);
  mpsh_spi_st_t s_r;
  mpsh_spi_st_t s_nxt;
  logic [2:0]   bit_r;
  logic         sel_rstn;

  // a dropped select restarts the byte count
  assign sel_rstn = resetn & ~serial_target_select_in_n;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.sh = {s_r.sh[6:0], sdi}; // R10
    if (bit_r == 3'h7) begin
      s_nxt.byte_q = {s_r.sh[6:0], sdi};
      s_nxt.tgl    = ~s_r.tgl;
    end
  end

  // sck idles high; edges that arrive while deselected leave the shifter untouched
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else if (!serial_target_select_in_n) begin // R9
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge sck or negedge sel_rstn) begin
    if (!sel_rstn) begin
      bit_r <= 3'h0;
    end else begin
      bit_r <= bit_r + 3'h1;
    end
  end

  assign byte_q   = s_r.byte_q;
  assign byte_tgl = s_r.tgl;
endmodule

// ### rtl/mpsh_top.sv
// serial host port: i2c, spi or async link feeding the command stream
// Operation
// R1 - i2c-select jumper fitted: act as i2c target; pull-ups are external
// R2 - spi-select jumper fitted: act as spi target
// R3 - no jumper fitted: act as asynchronous serial receiver
// R4 - default i2c target address is 0x50 when nothing is stored
// R5 - new address is even 0x00..0xfe; its lsb is forced to zero
// R6 - a changed address is written to non-volatile storage
// R7 - selecting spi or async mode restores the default address
// R8 - i2c traffic up to 400 khz is accepted; host keeps that limit
// R9 - spi clock idles high; data taken only while select is active
// R10 - spi data bits are sampled on the rising serial clock edge
// R11 - async frames: 8 data bits, no parity, one stop, no handshake
// R12 - default async rate is 9600 baud when nothing is stored
// R13 - changed rate is stored; i2c or spi mode restores the default
// R14 - prefix, 0x62, then one byte loads the new i2c address
// R15 - host waits 20 us after an address change before more input
// R16 - prefix, 0x61, then code 1..8 switches the async baud rate
// R17 - codes map to 300,1200,2400,9600,14400,19200,57600,115200 baud
// R18 - host waits 20 us after a rate change before more input
// R19 - an out-of-range rate code is discarded, rate unchanged
// R20 - every setting command is prefix 0xfe, code, then parameters
// R21 - i2c ack only when address bits 7..1 match the stored ones
// R22 - received bytes go to the decoder in order, none dropped
`timescale 1ns/1ps
`include "mpsh_defs.svh"
module mpsh_top
  import mpsh_pkg::*;
#(
  parameter int CLK_HZ = `MPSH_CLK_HZ
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       rx_in,
  input  wire logic       scl_sck_in,
  input  wire logic       sda_sdi_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       serial_target_select_in_n,
  input  wire logic       spi_mode_jumper,
  input  wire logic       i2c_mode_jumper,
  input  wire logic       nv_valid,
  input  wire logic [7:0] nv_i2c_addr,
  input  wire logic [3:0] nv_baud_code,
  output logic      [7:0] byte_data,
  output logic            byte_valid,
  output logic      [7:0] i2c_addr,
  output logic      [3:0] baud_code,
  output logic      [1:0] link_mode,
  output logic            nv_write
);
  localparam logic [15:0] SETTLE_C =
    16'(`MPSH_SETTLE_US * (CLK_HZ / `MPSH_HZ_PER_MHZ));

  mpsh_top_st_t s_r;
  mpsh_top_st_t s_nxt;

  logic [`MPSH_SYNC_W-1:0] pin_q;
  logic       rx_q;
  logic       scl_q;
  logic       sda_q;
  logic       spi_j_q;
  logic       i2c_j_q;
  logic       tgl_q;
  logic [7:0] spi_byte;
  logic       spi_tgl;

  logic       bv;
  logic [7:0] bd;
  logic [7:0] ib;
  logic [19:0] div;
  mpsh_mode_t jm;
  logic       i_start;
  logic       i_stop;
  logic       i_rise;
  logic       i_fall;

  mpsh_sync #(
    .W (`MPSH_SYNC_W)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({rx_in, scl_sck_in, sda_sdi_in,
              spi_mode_jumper, i2c_mode_jumper, spi_tgl}),
    .q      (pin_q)
  );

  assign {rx_q, scl_q, sda_q, spi_j_q, i2c_j_q, tgl_q} = pin_q;

  mpsh_spi_link u_spi ( // R9 R10
    .sck                       (scl_sck_in),
    .resetn                    (resetn),
    .serial_target_select_in_n (serial_target_select_in_n),
    .sdi                       (sda_sdi_in),
    .byte_q                    (spi_byte),
    .byte_tgl                  (spi_tgl)
  );

  function automatic logic [19:0] div_of(input logic [3:0] c);
    case (c) // R17
      4'h1:    div_of = 20'(CLK_HZ / `MPSH_BAUD_1);
      4'h2:    div_of = 20'(CLK_HZ / `MPSH_BAUD_2);
      4'h3:    div_of = 20'(CLK_HZ / `MPSH_BAUD_3);
      4'h5:    div_of = 20'(CLK_HZ / `MPSH_BAUD_5);
      4'h6:    div_of = 20'(CLK_HZ / `MPSH_BAUD_6);
      4'h7:    div_of = 20'(CLK_HZ / `MPSH_BAUD_7);
      4'h8:    div_of = 20'(CLK_HZ / `MPSH_BAUD_8);
      default: div_of = 20'(CLK_HZ / `MPSH_BAUD_4);
    endcase
  endfunction

  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c >= `MPSH_BAUD_MIN) && (c <= `MPSH_BAUD_MAX);
  endfunction

  // parameter bytes of other commands must not be taken as a prefix
  function automatic logic [3:0] param_len(input logic [7:0] c);
    case (c)
      `MPSH_CMD_CURSOR,
      `MPSH_CMD_CONTRAST,
      `MPSH_CMD_BRIGHT,
      `MPSH_CMD_RAW:   param_len = `MPSH_ONE_LEN;
      `MPSH_CMD_GLYPH: param_len = `MPSH_GLYPH_LEN;
      default:         param_len = 4'h0;
    endcase
  endfunction

  always_comb begin
    s_nxt       = s_r;
    s_nxt.out_v = 1'b0;
    s_nxt.nv_wr = 1'b0;
    bv          = 1'b0;
    bd          = 8'h00;
    ib          = {s_r.ish[6:0], sda_q};
    div         = div_of(s_r.baud);
    i_rise      = scl_q & ~s_r.scl_p;
    i_fall      = ~scl_q & s_r.scl_p;
    i_start     = scl_q & s_r.scl_p & s_r.sda_p & ~sda_q;
    i_stop      = scl_q & s_r.scl_p & ~s_r.sda_p & sda_q;
    if (i2c_j_q) begin
      jm = MODE_I2C; // R1
    end else if (spi_j_q) begin
      jm = MODE_SPI; // R2
    end else begin
      jm = MODE_UART; // R3
    end
    s_nxt.scl_p    = scl_q;
    s_nxt.sda_p    = sda_q;
    s_nxt.spi_prev = tgl_q;

    // lands first, so a mode change or a fresh command in this cycle wins
    if (s_r.pend != P_NONE) begin
      if (s_r.settle != 16'h0) begin
        s_nxt.settle = s_r.settle - 16'h1;
      end else begin
        s_nxt.pend  = P_NONE;
        s_nxt.nv_wr = 1'b1; // R6 R13
        if (s_r.pend == P_ADDR) begin
          s_nxt.i2c_addr = s_r.pval;
        end else begin
          s_nxt.baud = s_r.pval[3:0];
        end
      end
    end

    if (!s_r.init_done) begin
      // let the jumper synchronisers settle before trusting them
      if (s_r.init != `MPSH_INIT_CYC) begin
        s_nxt.init = s_r.init + 4'h1;
      end else begin
        s_nxt.init_done = 1'b1;
        s_nxt.mode      = jm;
        if (jm == MODE_I2C && nv_valid) begin
          s_nxt.i2c_addr = {nv_i2c_addr[7:1], 1'b0};
        end else begin
          s_nxt.i2c_addr = `MPSH_DEF_I2C_ADDR; // R4 R7
        end
        if (jm == MODE_UART && nv_valid && code_ok(nv_baud_code)) begin
          s_nxt.baud = nv_baud_code;
        end else begin
          s_nxt.baud = `MPSH_DEF_BAUD; // R12 R13
        end
      end
    end else if (jm != s_r.mode) begin
      s_nxt.mode     = jm;
      s_nxt.urx      = U_IDLE;
      s_nxt.i2c      = I_IDLE;
      s_nxt.sda_oe_n = 1'b1;
      s_nxt.cmd      = C_IDLE;
      s_nxt.pend     = P_NONE;
      if (jm != MODE_I2C) begin
        s_nxt.i2c_addr = `MPSH_DEF_I2C_ADDR; // R7
      end
      if (jm != MODE_UART) begin
        s_nxt.baud = `MPSH_DEF_BAUD; // R13
      end
      s_nxt.nv_wr = 1'b1;
    end else begin
      // asynchronous receiver, sampled mid-bit
      if (s_r.mode == MODE_UART) begin
        case (s_r.urx) // R11
          U_IDLE: begin
            if (!rx_q) begin
              s_nxt.urx  = U_START;
              s_nxt.ucnt = div >> 1;
            end
          end
          U_START: begin
            if (s_r.ucnt != 20'h0) begin
              s_nxt.ucnt = s_r.ucnt - 20'h1;
            end else if (!rx_q) begin
              s_nxt.urx  = U_DATA;
              s_nxt.ucnt = div - 20'h1;
              s_nxt.ubit = 3'h0;
            end else begin
              s_nxt.urx = U_IDLE;
            end
          end
          U_DATA: begin
            if (s_r.ucnt != 20'h0) begin
              s_nxt.ucnt = s_r.ucnt - 20'h1;
            end else begin
              s_nxt.ush  = {rx_q, s_r.ush[7:1]};
              s_nxt.ucnt = div - 20'h1;
              s_nxt.ubit = s_r.ubit + 3'h1;
              if (s_r.ubit == 3'h7) begin
                s_nxt.urx = U_STOP;
              end
            end
          end
          U_STOP: begin
            if (s_r.ucnt != 20'h0) begin
              s_nxt.ucnt = s_r.ucnt - 20'h1;
            end else begin
              // a low stop bit is a framing error and the byte is dropped
              s_nxt.urx = U_IDLE;
              if (rx_q) begin
                bv = 1'b1;
                bd = s_r.ush;
              end
            end
          end
          default: s_nxt.urx = U_IDLE;
        endcase
      end

      // i2c target, write transfers only; filtered pins keep up to 400 khz
      if (s_r.mode == MODE_I2C) begin // R8
        if (i_start) begin
          s_nxt.i2c      = I_ADDR;
          s_nxt.ibit     = 4'h0;
          s_nxt.sda_oe_n = 1'b1;
        end else if (i_stop) begin
          s_nxt.i2c      = I_IDLE;
          s_nxt.sda_oe_n = 1'b1;
        end else begin
          case (s_r.i2c)
            I_ADDR, I_DATA: begin
              if (i_rise) begin
                s_nxt.ish  = ib;
                s_nxt.ibit = s_r.ibit + 4'h1;
                if (s_r.ibit == 4'h7 && s_r.i2c == I_ADDR) begin
                  if (ib[7:1] == s_r.i2c_addr[7:1] && !ib[0]) begin // R21
                    s_nxt.i2c = I_AACK;
                  end else begin
                    s_nxt.i2c = I_IDLE;
                  end
                end else if (s_r.ibit == 4'h7) begin
                  s_nxt.i2c = I_DACK;
                  bv        = 1'b1;
                  bd        = ib;
                end
              end
            end
            I_AACK, I_DACK: begin
              // first low phase drives ack, the next releases the line
              if (i_fall) begin
                if (s_r.sda_oe_n) begin
                  s_nxt.sda_oe_n = 1'b0;
                end else begin
                  s_nxt.sda_oe_n = 1'b1;
                  s_nxt.i2c      = I_DATA;
                  s_nxt.ibit     = 4'h0;
                end
              end
            end
            I_IDLE: s_nxt.sda_oe_n = 1'b1;
            default: begin
              s_nxt.i2c      = I_IDLE;
              s_nxt.sda_oe_n = 1'b1;
            end
          endcase
        end
      end

      // spi byte crosses by toggle; data stays put for eight sck edges
      if (s_r.mode == MODE_SPI && tgl_q != s_r.spi_prev) begin
        bv = 1'b1;
        bd = spi_byte;
      end
    end

    if (bv) begin
      s_nxt.out_d = bd; // R22
      s_nxt.out_v = 1'b1;
    end

    if (bv) begin
      case (s_r.cmd) // R20
        C_IDLE: begin
          if (bd == `MPSH_PREFIX) begin
            s_nxt.cmd = C_CODE;
          end
        end
        C_CODE: begin
          if (bd == `MPSH_CMD_ADDR) begin
            s_nxt.cmd  = C_PARAM;
            s_nxt.kind = P_ADDR;
          end else if (bd == `MPSH_CMD_BAUD) begin
            s_nxt.cmd  = C_PARAM;
            s_nxt.kind = P_BAUD;
          end else if (param_len(bd) != 4'h0) begin
            s_nxt.cmd  = C_SKIP;
            s_nxt.skip = param_len(bd) - 4'h1;
          end else begin
            s_nxt.cmd = C_IDLE;
          end
        end
        C_PARAM: begin
          s_nxt.cmd = C_IDLE;
          if (s_r.kind == P_ADDR) begin
            s_nxt.pend   = P_ADDR; // R14
            s_nxt.pval   = {bd[7:1], 1'b0}; // R5
            s_nxt.settle = SETTLE_C - 16'h1;
          end else if (code_ok(bd[3:0]) && bd[7:4] == 4'h0) begin // R19
            s_nxt.pend   = P_BAUD; // R16
            s_nxt.pval   = bd;
            s_nxt.settle = SETTLE_C - 16'h1;
          end
          // illegal rate code: nothing pending, rate kept
        end
        C_SKIP: begin
          if (s_r.skip == 4'h0) begin
            s_nxt.cmd = C_IDLE;
          end else begin
            s_nxt.skip = s_r.skip - 4'h1;
          end
        end
        default: s_nxt.cmd = C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r          <= '0;
      s_r.mode     <= MODE_UART;
      s_r.i2c_addr <= `MPSH_DEF_I2C_ADDR;
      s_r.baud     <= `MPSH_DEF_BAUD;
      s_r.sda_oe_n <= 1'b1;
      s_r.scl_p    <= 1'b1;
      s_r.sda_p    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out    = s_r.sda_o;
  assign sda_oe_n   = s_r.sda_oe_n;
  assign byte_data  = s_r.out_d;
  assign byte_valid = s_r.out_v;
  assign i2c_addr   = s_r.i2c_addr;
  assign baud_code  = s_r.baud;
  assign link_mode  = s_r.mode;
  assign nv_write   = s_r.nv_wr;
endmodule

// ### tb/mpsh_top_assertions.sv
// concurrent checks on the serial host port outputs
`timescale 1ns/1ps
module mpsh_top_assertions (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       scl_sck_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       byte_valid,
  input wire logic [7:0] i2c_addr,
  input wire logic [3:0] baud_code,
  input wire logic [1:0] link_mode,
  input wire logic       nv_write
);
  logic [4:0] up_r;
  logic       run;
  // init loads stored settings without a store pulse: keep clear of it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_r <= 5'h00;
    end else if (up_r != 5'h1f) begin
      up_r <= up_r + 5'h01;
    end
  end
  assign run = (up_r == 5'h1f);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_left_i2c;
    run && $changed(link_mode) && link_mode != 2'h2;
  endsequence
  sequence s_left_async;
    run && $changed(link_mode) && link_mode != 2'h0;
  endsequence
  sequence s_ack_end;
    !sda_oe_n && $fell(scl_sck_in);
  endsequence
  a_valid_pulse: assert property (byte_valid |=> !byte_valid)
    else $error("byte_valid longer than one cycle");
  a_ack_i2c_only: assert property (!sda_oe_n |->
    link_mode == 2'h2 || $past(link_mode) == 2'h2)
    else $error("data line pulled outside i2c mode");
  a_drive_low: assert property (!sda_oe_n |-> sda_out == 1'b0)
    else $error("data line driven high");
  a_addr_even: assert property (i2c_addr[0] == 1'b0)
    else $error("i2c address odd");
  a_baud_legal: assert property (baud_code inside {[4'h1:4'h8]})
    else $error("rate code out of range");
  a_cfg_saved: assert property (run && ($changed(i2c_addr) ||
    $changed(baud_code)) |-> nv_write)
    else $error("setting changed without store");
  a_addr_restore: assert property (s_left_i2c |->
    ##[0:2] i2c_addr == 8'h50)
    else $error("address not restored");
  a_baud_restore: assert property (s_left_async |->
    ##[0:2] baud_code == 4'h4)
    else $error("rate not restored");
  a_ack_release: assert property (s_ack_end |-> ##[1:8] sda_oe_n)
    else $error("ack held too long");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_sck_in)
    else $error("ack started with clock high");
endmodule

bind mpsh_top mpsh_top_assertions i_mpsh_top_assertions (
  .clk        (clk),
  .resetn     (resetn),
  .scl_sck_in (scl_sck_in),
  .sda_out    (sda_out),
  .sda_oe_n   (sda_oe_n),
  .byte_valid (byte_valid),
  .i2c_addr   (i2c_addr),
  .baud_code  (baud_code),
  .link_mode  (link_mode),
  .nv_write   (nv_write)
);

// ### tb/mpsh_host_model.sv
// host controller model: async, spi and i2c write traffic
`timescale 1ns/1ps
module mpsh_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      rx,
  output logic      sck,
  output logic      sdo,
  output logic      sel_n
);
  localparam int QTR = 104; // 315 clk of 8 ns per scl bit
  initial begin
    rx = 1'b1;
    sck = 1'b1;
    sdo = 1'b1;
    sel_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic uart_send(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) rx <= f[i];
      wait_clk(div - 1);
    end
  endtask
  // mode 3: data moves on the fall, is taken on the rise
  task automatic spi_send(input logic [7:0] b, input logic sel);
    @(posedge clk) sel_n <= !sel;
    #27;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      sdo = b[i];
      #24;
      sck = 1'b1;
      #24;
    end
    sdo = !b[0];
    #24;
    sel_n = 1'b1;
  endtask
  task automatic i2c_bit(input logic v, output logic got);
    @(posedge clk) sdo <= v;
    wait_clk(QTR);
    @(posedge clk) sck <= 1'b1;
    wait_clk(QTR);
    got = sda_line;
    @(posedge clk) sck <= 1'b0;
    wait_clk(QTR);
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], g);
    end
    i2c_bit(1'b1, g);
    ack = !g;
  endtask
  task automatic i2c_write(input logic [7:0] a, input logic [7:0] d,
                           output logic aa, output logic ad);
    @(posedge clk) sdo <= 1'b1;
    wait_clk(QTR);
    @(posedge clk) sdo <= 1'b0;
    wait_clk(QTR);
    @(posedge clk) sck <= 1'b0;
    wait_clk(QTR);
    i2c_byte(a, aa);
    ad = 1'b0;
    if (aa) begin
      i2c_byte(d, ad);
    end
    @(posedge clk) sdo <= 1'b0;
    wait_clk(QTR);
    @(posedge clk) sck <= 1'b1;
    wait_clk(QTR);
    @(posedge clk) sdo <= 1'b1;
    wait_clk(QTR);
  endtask
endmodule

// ### tb/mpsh_top_tb.sv
// self-checking bench for the serial host port
`timescale 1ns/1ps
module mpsh_top_tb;
  localparam int CLK_HZ = 2000000;
  localparam int SETTLE = CLK_HZ / 50000;
  int         baud_tab [1:8] = '{300, 1200, 2400, 9600, 14400, 19200,
                                 57600, 115200};
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       spi_j = 1'b0;
  logic       i2c_j = 1'b0;
  logic       nv_valid = 1'b0;
  logic [7:0] nv_addr = 8'h00;
  logic [3:0] nv_baud = 4'h0;
  logic       rx, sck, sdo, sel_n, sda_line;
  logic       sda_out, sda_oe_n, byte_valid, nv_write;
  logic [7:0] byte_data, i2c_addr;
  logic [3:0] baud_code;
  logic [1:0] link_mode;
  logic [7:0] expq [$];
  logic [7:0] codes [9] = '{8'h00, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05,
                            8'h01, 8'h02, 8'h03};
  int         errors, checks_done, nv_cnt, cur, n0;
  assign sda_line = sdo & (sda_oe_n | sda_out);
  mpsh_top #(.CLK_HZ(CLK_HZ)) i_mpsh_top (
    .clk                       (clk),
    .resetn                    (resetn),
    .rx_in                     (rx),
    .scl_sck_in                (sck),
    .sda_sdi_in                (sda_line),
    .sda_out                   (sda_out),
    .sda_oe_n                  (sda_oe_n),
    .serial_target_select_in_n (sel_n),
    .spi_mode_jumper           (spi_j),
    .i2c_mode_jumper           (i2c_j),
    .nv_valid                  (nv_valid),
    .nv_i2c_addr               (nv_addr),
    .nv_baud_code              (nv_baud),
    .byte_data                 (byte_data),
    .byte_valid                (byte_valid),
    .i2c_addr                  (i2c_addr),
    .baud_code                 (baud_code),
    .link_mode                 (link_mode),
    .nv_write                  (nv_write)
  );
  mpsh_host_model i_mpsh_host_model (
    .clk      (clk),
    .sda_line (sda_line),
    .rx       (rx),
    .sck      (sck),
    .sdo      (sdo),
    .sel_n    (sel_n)
  );
  always #4 clk = ~clk;
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (nv_write === 1'b1) nv_cnt++;
    if (byte_valid === 1'b1) begin
      if (expq.size() == 0) check8(byte_data, 8'hxx);
      else check8(byte_data, expq.pop_front());
    end
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset();
    @(posedge clk) resetn <= 1'b0;
    wait_clk(5);
    @(posedge clk) resetn <= 1'b1;
    wait_clk(20);
  endtask
  task automatic drain();
    for (int n = 0; n < 60000 && expq.size() != 0; n++) @(posedge clk);
    check8(8'(expq.size()), 8'h00);
  endtask
  task automatic uart(input logic [7:0] b);
    expq.push_back(b);
    i_mpsh_host_model.uart_send(b, CLK_HZ / baud_tab[cur]);
  endtask
  task automatic spi(input logic [7:0] b);
    expq.push_back(b);
    i_mpsh_host_model.spi_send(b, 1'b1);
  endtask
  task automatic i2c(input logic [7:0] a, d, input logic ok);
    logic aa, ad;
    if (ok) expq.push_back(d);
    i_mpsh_host_model.i2c_write(a, d, aa, ad);
    check8({7'h0, aa}, {7'h0, ok});
    check8({7'h0, ad}, {7'h0, ok});
  endtask
  task automatic set_mode(input logic s, i, input logic [1:0] m);
    @(posedge clk) spi_j <= s;
    i2c_j <= i;
    n0 = nv_cnt;
    wait_clk(30);
    check8({6'h0, link_mode}, {6'h0, m});
    check8(8'(nv_cnt - n0), 8'h01);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge clk);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    nv_cnt = 0;
    cur = 4;
    do_reset();
    check8({6'h0, link_mode}, 8'h00);
    check8(i2c_addr, 8'h50);
    check8({4'h0, baud_code}, 8'h04);
    $display("test defaults done");
    foreach (codes[k]) begin
      n0 = nv_cnt;
      uart(8'hfe);
      uart(8'h61);
      uart(codes[k]);
      drain();
      wait_clk(SETTLE + 10);
      if (codes[k] inside {[8'h01:8'h08]}) begin
        cur = codes[k];
        check8(8'(nv_cnt - n0), 8'h01);
      end
      check8({4'h0, baud_code}, 8'(cur));
      if (cur < 4) begin
        set_mode(1'b1, 1'b0, 2'h1);
        check8({4'h0, baud_code}, 8'h04);
        set_mode(1'b0, 1'b0, 2'h0);
        cur = 4;
      end
    end
    $display("test baud codes done");
    n0 = nv_cnt;
    uart(8'hfe);
    uart(8'h62);
    uart(8'h35);
    drain();
    wait_clk(SETTLE + 10);
    check8(i2c_addr, 8'h34);
    check8(8'(nv_cnt - n0), 8'h01);
    set_mode(1'b0, 1'b1, 2'h2);
    check8(i2c_addr, 8'h34);
    i2c(8'h34, 8'h5a, 1'b1);
    i2c(8'h50, 8'h11, 1'b0);
    i2c(8'h35, 8'h00, 1'b0);
    i2c(8'h34, 8'hfe, 1'b1);
    i2c(8'h34, 8'h62, 1'b1);
    i2c(8'h34, 8'h23, 1'b1);
    wait_clk(SETTLE + 10);
    check8(i2c_addr, 8'h22);
    i2c(8'h22, 8'ha5, 1'b1);
    $display("test i2c done");
    set_mode(1'b1, 1'b0, 2'h1);
    check8(i2c_addr, 8'h50);
    spi(8'hc3);
    spi(8'h3c);
    i_mpsh_host_model.spi_send(8'h99, 1'b0);
    spi(8'h81);
    spi(8'hfe);
    spi(8'h45);
    spi(8'hfe);
    spi(8'h61);
    spi(8'h05);
    drain();
    wait_clk(SETTLE + 10);
    check8({4'h0, baud_code}, 8'h04);
    $display("test spi done");
    nv_valid <= 1'b1;
    nv_addr <= 8'h71;
    nv_baud <= 4'h6;
    @(posedge clk) i2c_j <= 1'b1;
    spi_j <= 1'b0;
    do_reset();
    check8({6'h0, link_mode}, 8'h02);
    check8(i2c_addr, 8'h70);
    i2c(8'h70, 8'h42, 1'b1);
    drain();
    $display("test stored settings done");
    print_verdict();
  end
endmodule
